// ===== hw/gcp_pkg.sv
// Purpose: shared constants and types for the gain, channel and power
//          configuration registers
// Assumes: 8-bit register port, page/address access on the control clock
// Notes:   every offset, reset value, field position and decode figure
//          lives here

package gcp_pkg;

	// register location
	localparam logic [7:0] GCP_PAGE_CFG       = 8'h00; // page holding the block
	localparam logic [7:0] GCP_ADDR_GAIN_CFG  = 8'h70; // gain_control_config
	localparam logic [7:0] GCP_ADDR_IN_EN     = 8'h73; // input_channel_enables
	localparam logic [7:0] GCP_ADDR_SLOT_EN   = 8'h74; // output_slot_enables
	localparam logic [7:0] GCP_ADDR_POWER_CONFIG   = 8'h75; // power_config

	// reset values
	localparam logic [7:0] GCP_RST_GAIN_CFG   = 8'he7; // level 14, gain 7
	localparam logic [7:0] GCP_RST_IN_EN      = 8'hf0; // ch1-4 on, ch5-8 off
	localparam logic [7:0] GCP_RST_SLOT_EN    = 8'h00; // all slots tri-state
	localparam logic [7:0] GCP_RST_POWER_CONFIG    = 8'h00; // everything down
	localparam logic [7:0] GCP_RDATA_UNMAPPED = 8'h00; // answer to other addr

	// gain_control_config fields
	localparam int GCP_LVL_MSB  = 7; // target_output_level top bit
	localparam int GCP_LVL_LSB  = 4; // target_output_level low bit
	localparam int GCP_GAIN_MSB = 3; // gain_ceiling top bit
	localparam int GCP_GAIN_LSB = 0; // gain_ceiling low bit

	// power_config fields
	localparam int GCP_PWR_BIAS = 7; // bias_supply_power_on
	localparam int GCP_PWR_CONV = 6; // converter_power_on
	localparam int GCP_PWR_SYNTH = 5; // synth_power_on
	localparam int GCP_PWR_LIVE = 4; // live_channel_power_change
	localparam int GCP_PWR_SPAN_MSB = 3; // live_channel_span top bit
	localparam int GCP_PWR_SPAN_LSB = 2; // live_channel_span low bit

	// decode figures, in dB
	localparam logic signed [7:0] GCP_LVL_BASE_DB  = -8'sd6; // code 0 level
	localparam logic [7:0]        GCP_LVL_STEP_DB  = 8'h02;  // fall per code
	localparam logic [7:0]        GCP_GAIN_BASE_DB = 8'h03;  // code 0 gain
	localparam logic [7:0]        GCP_GAIN_STEP_DB = 8'h03;  // rise per code
	localparam logic [3:0]        GCP_GAIN_MAX_CODE = 4'hd;  // last legal code

	// channel counts
	localparam int GCP_NUM_CH     = 8; // input and output channels
	localparam int GCP_NUM_ANALOG = 4; // ch1-4 may be analog

	// live span masks, bit 7 = channel 1
	localparam logic [7:0] GCP_SPAN_CH12 = 8'hc0; // span code 0
	localparam logic [7:0] GCP_SPAN_CH14 = 8'hf0; // span code 1
	localparam logic [7:0] GCP_SPAN_CH16 = 8'hfc; // span code 2
	localparam logic [7:0] GCP_SPAN_CH18 = 8'hff; // span code 3

	// power_config as a carrier
	typedef struct packed {
		logic       bias_on;  // bias_supply_power_on
		logic       conv_on;  // converter_power_on
		logic       synth_on; // synth_power_on
		logic       live;     // live_channel_power_change
		logic [1:0] span;     // live_channel_span
		logic [1:0] spare;    // reserved, stored as written
	} gcp_pwr_type;

	// decoded gain control settings
	typedef struct packed {
		logic signed [7:0] level_db; // target level in dB
		logic [7:0]        gain_db;  // ceiling in dB
		logic              gain_ok;  // gain code is defined
	} gcp_agc_type;

endpackage

// ===== hw/gcp_gain_decode.sv
// Purpose: turns the two gain control codes into dB figures
// Assumes: linear steps between the end points
// Notes:   purely combinational; the caller registers the result

`timescale 1ns/1ps

module gcp_gain_decode
	import gcp_pkg::*;
(
	input  wire logic [3:0]  level_code_i, // target_output_level code
	input  wire logic [3:0]  gain_code_i,  // gain_ceiling code
	output gcp_agc_type      agc_o         // decoded settings
);

	wire logic [7:0] level_wide; // level code widened to 8 bits
	wire logic [7:0] gain_wide;  // gain code widened to 8 bits

	assign level_wide = {4'h0, level_code_i};
	assign gain_wide  = {4'h0, gain_code_i};

	// level falls 2 dB per code from -6 dB
	assign agc_o.level_db = GCP_LVL_BASE_DB
		- $signed(level_wide * GCP_LVL_STEP_DB); // [RULE1] [RULE16]
	// ceiling rises 3 dB per code from 3 dB
	assign agc_o.gain_db = GCP_GAIN_BASE_DB
		+ gain_wide * GCP_GAIN_STEP_DB; // [RULE2] [RULE16]
	// codes 14 and 15 have no defined ceiling
	assign agc_o.gain_ok = (gain_code_i <= GCP_GAIN_MAX_CODE); // [RULE3]

endmodule

// ===== hw/gcp_regs.sv
// Purpose: gain, channel and power configuration register bank
// Assumes: the control-port front end presents page, address and
//          strobes on CLOCK_I; channel sources and slot data are on
//          the same clock
// Notes:   one read data cycle of latency, writes take effect at once
//
// Contract
// [RULE1] level code decodes to -6 dB minus 2 dB/code
// [RULE2] gain code decodes to 3 dB plus 3 dB/code
// [RULE3] software avoids reserved gain codes 14, 15
// [RULE4] gain config at 0x70, resets to 0xe7
// [RULE5] one input enable bit per channel, ch1 bit7
// [RULE6] channels 5-8 use the PDM path only
// [RULE7] input enables reset to 0xf0
// [RULE8] slot bit set drives slot, else tri-state
// [RULE9] slot enables reset to zero
// [RULE10] bit 7 powers the bias supply
// [RULE11] bit 6 powers enabled channels, else none
// [RULE12] bit 5 powers the synthesiser
// [RULE13] power config at 0x75 resets to zero
// [RULE14] live bit permits channel changes while recording
// [RULE15] span code selects channels 1-2/4/6/8
// [RULE16] intermediate codes step linearly

`timescale 1ns/1ps

module gcp_regs
	import gcp_pkg::*;
#(
	parameter int NUM_CH = GCP_NUM_CH // channel count
)
(
	input  wire logic              CLOCK_I,        // 20 MHz control clock
	input  wire logic              SYS_RST_I,      // sync reset, high
	input  wire logic [7:0]        REG_PAGE_I,     // register page
	input  wire logic [7:0]        REG_ADDR_I,     // register address
	input  wire logic              REG_WR_I,       // write strobe
	input  wire logic              REG_RD_I,       // read strobe
	input  wire logic [7:0]        REG_WDATA_I,    // write data
	output logic [7:0]             REG_RDATA_O,    // read data
	output logic                   REG_RVALID_O,   // read data valid
	input  wire logic [3:0]        CH_PDM_SEL_I,   // ch1-4 source is PDM
	input  wire logic [NUM_CH-1:0] SLOT_DATA_I,    // per-slot serial bit
	output logic [NUM_CH-1:0]      SLOT_OUT_O,     // per-slot output
	output logic [NUM_CH-1:0]      SLOT_OE_O,      // per-slot drive enable
	output logic signed [7:0]      AGC_LEVEL_DB_O, // target level, dB
	output logic [7:0]             AGC_GAIN_DB_O,  // gain ceiling, dB
	output logic                   AGC_GAIN_OK_O,  // gain code defined
	output logic                   BIAS_ON_O,      // bias supply on
	output logic                   SYNTH_ON_O,     // synthesiser on
	output logic [3:0]             ANALOG_ON_O,    // analog ch1-4 power
	output logic [NUM_CH-1:0]      PDM_ON_O,       // PDM path power
	output logic [NUM_CH-1:0]      CH_STATUS_O     // channel power state
);

	// register storage
	logic [7:0]        gain_cfg_reg;  // gain_control_config
	logic [7:0]        in_en_reg;     // input_channel_enables
	logic [7:0]        slot_en_reg;   // output_slot_enables
	gcp_pwr_type       pwr_reg;       // power_config
	logic [NUM_CH-1:0] ch_pwr_reg;    // powered channels
	logic [NUM_CH-1:0] ch_pwr_next;   // next powered channels
	logic [7:0]        rdata_reg;     // read data
	logic              rvalid_reg;    // read answer pulse
	gcp_agc_type       agc_reg;       // registered decode
	logic [NUM_CH-1:0] slot_out_reg;  // registered slot data

	// decode wires
	wire logic        page_hit;   // access targets our page
	wire logic        wr_gain;    // write gain_control_config
	wire logic        wr_in;      // write input_channel_enables
	wire logic        wr_slot;    // write output_slot_enables
	wire logic        wr_pwr;     // write power_config
	wire logic [7:0]  rd_mux;     // selected read value
	wire logic        recording;  // some channel is powered
	wire logic [7:0]  span_mask;  // channels under live control
	wire logic [7:0]  slot_en_next; // slot enables after this edge
	wire logic [NUM_CH-1:0] may_change; // channels free to follow
	gcp_agc_type      agc_comb;   // decoder output

	// address match, used by every write select
	function automatic logic hit(input logic [7:0] addr,
		input logic [7:0] want);
		hit = (addr == want);
	endfunction

	// span code to channel mask
	function automatic logic [7:0] span_of(input logic [1:0] code);
		unique case (code)
			2'h0: span_of = GCP_SPAN_CH12; // channels 1-2
			2'h1: span_of = GCP_SPAN_CH14; // channels 1-4
			2'h2: span_of = GCP_SPAN_CH16; // channels 1-6
			2'h3: span_of = GCP_SPAN_CH18; // channels 1-8
		endcase
	endfunction

	assign page_hit = (REG_PAGE_I == GCP_PAGE_CFG);
	assign wr_gain  = REG_WR_I && page_hit
		&& hit(REG_ADDR_I, GCP_ADDR_GAIN_CFG); // [RULE4]
	assign wr_in    = REG_WR_I && page_hit
		&& hit(REG_ADDR_I, GCP_ADDR_IN_EN); // [RULE5]
	assign wr_slot  = REG_WR_I && page_hit
		&& hit(REG_ADDR_I, GCP_ADDR_SLOT_EN); // [RULE8]
	assign wr_pwr   = REG_WR_I && page_hit
		&& hit(REG_ADDR_I, GCP_ADDR_POWER_CONFIG); // [RULE13]

	// slot data is masked with the enables that stand after this edge,
	// so a slot being released never shows one cycle of stale data
	assign slot_en_next = wr_slot ? REG_WDATA_I : slot_en_reg; // [RULE8]

	// read mux; other pages and addresses answer zero
	assign rd_mux =
		!page_hit ? GCP_RDATA_UNMAPPED :
		hit(REG_ADDR_I, GCP_ADDR_GAIN_CFG) ? gain_cfg_reg :
		hit(REG_ADDR_I, GCP_ADDR_IN_EN)    ? in_en_reg :
		hit(REG_ADDR_I, GCP_ADDR_SLOT_EN)  ? slot_en_reg :
		hit(REG_ADDR_I, GCP_ADDR_POWER_CONFIG)  ? pwr_reg :
		GCP_RDATA_UNMAPPED;

	// gain code decoder
	gcp_gain_decode u_decode (
		.level_code_i (gain_cfg_reg[GCP_LVL_MSB:GCP_LVL_LSB]),
		.gain_code_i  (gain_cfg_reg[GCP_GAIN_MSB:GCP_GAIN_LSB]),
		.agc_o        (agc_comb)
	);

	// live channel control: with the live bit clear, a recording
	// device freezes every channel; with it set, only channels in
	// the span may follow their enables
	assign recording = |ch_pwr_reg;
	assign span_mask = span_of(pwr_reg.span); // [RULE15]
	assign may_change = !recording ? {NUM_CH{1'b1}} :
		pwr_reg.live ? span_mask[NUM_CH-1:0] :
		{NUM_CH{1'b0}}; // [RULE14]

	// per-channel power target
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			assign ch_pwr_next[gi] = !pwr_reg.conv_on ? 1'b0 :
				may_change[gi] ? in_en_reg[gi] :
				ch_pwr_reg[gi]; // [RULE11] [RULE14]
		end
	endgenerate

	// configuration storage
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			gain_cfg_reg <= GCP_RST_GAIN_CFG; // [RULE4]
			in_en_reg    <= GCP_RST_IN_EN;    // [RULE7]
			slot_en_reg  <= GCP_RST_SLOT_EN;  // [RULE9]
			pwr_reg      <= GCP_RST_POWER_CONFIG;  // [RULE13]
		end else begin
			if (wr_gain) begin
				gain_cfg_reg <= REG_WDATA_I;
			end
			if (wr_in) begin
				in_en_reg <= REG_WDATA_I; // [RULE5]
			end
			if (wr_slot) begin
				slot_en_reg <= REG_WDATA_I; // [RULE8]
			end
			if (wr_pwr) begin
				pwr_reg <= REG_WDATA_I; // [RULE10] [RULE12]
			end
		end
	end

	// channel power state follows one cycle after its cause
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			ch_pwr_reg <= '0;
		end else begin
			ch_pwr_reg <= ch_pwr_next;
		end
	end

	// read answer and registered data outputs
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			rdata_reg    <= GCP_RDATA_UNMAPPED;
			rvalid_reg   <= 1'b0;
			agc_reg      <= '0;
			slot_out_reg <= '0;
		end else begin
			rvalid_reg   <= REG_RD_I;
			if (REG_RD_I) begin
				rdata_reg <= rd_mux;
			end
			agc_reg      <= agc_comb; // [RULE1] [RULE2]
			slot_out_reg <= SLOT_DATA_I & slot_en_next; // [RULE8]
		end
	end

	// outputs
	assign REG_RDATA_O    = rdata_reg;
	assign REG_RVALID_O   = rvalid_reg;
	assign SLOT_OUT_O     = slot_out_reg;
	// disabled slots are released, not driven low
	assign SLOT_OE_O      = slot_en_reg; // [RULE8]
	assign AGC_LEVEL_DB_O = agc_reg.level_db;
	assign AGC_GAIN_DB_O  = agc_reg.gain_db;
	assign AGC_GAIN_OK_O  = agc_reg.gain_ok; // [RULE3]
	assign BIAS_ON_O      = pwr_reg.bias_on;  // [RULE10]
	assign SYNTH_ON_O     = pwr_reg.synth_on; // [RULE12]
	assign CH_STATUS_O    = ch_pwr_reg;
	// ch1-4 go analog unless their source is PDM; ch5-8 are PDM only
	assign ANALOG_ON_O = ch_pwr_reg[NUM_CH-1 -: GCP_NUM_ANALOG]
		& ~CH_PDM_SEL_I; // [RULE6]
	assign PDM_ON_O = {ch_pwr_reg[NUM_CH-1 -: GCP_NUM_ANALOG]
		& CH_PDM_SEL_I,
		ch_pwr_reg[NUM_CH-GCP_NUM_ANALOG-1:0]}; // [RULE6]

	// checks

	chk_level_decode: assert property (@(posedge CLOCK_I) // [RULE1]
		disable iff (SYS_RST_I)
		!$past(SYS_RST_I) |-> AGC_LEVEL_DB_O == GCP_LVL_BASE_DB
		- $signed({3'h0,
		$past(gain_cfg_reg[GCP_LVL_MSB:GCP_LVL_LSB]), 1'b0}))
		else $error("target level decode wrong");

	chk_gain_decode: assert property (@(posedge CLOCK_I) // [RULE2]
		disable iff (SYS_RST_I)
		$past(gain_cfg_reg[GCP_GAIN_MSB:GCP_GAIN_LSB]) == GCP_GAIN_MAX_CODE
		&& !$past(SYS_RST_I)
		|-> AGC_GAIN_DB_O == 8'h2a)
		else $error("gain ceiling decode wrong");

	chk_gain_reserved: assert property (@(posedge CLOCK_I) // [RULE3]
		disable iff (SYS_RST_I)
		$past(gain_cfg_reg[3:0]) >= 4'he && !$past(SYS_RST_I)
		|-> !AGC_GAIN_OK_O)
		else $error("reserved gain code flagged valid");

	chk_reset_values: assert property (@(posedge CLOCK_I) // [RULE4]
		$past(SYS_RST_I) |-> gain_cfg_reg == GCP_RST_GAIN_CFG
		&& in_en_reg == GCP_RST_IN_EN
		&& slot_en_reg == GCP_RST_SLOT_EN
		&& pwr_reg == GCP_RST_POWER_CONFIG) // [RULE7] [RULE9] [RULE13]
		else $error("reset value wrong");

	chk_in_en_write: assert property (@(posedge CLOCK_I) // [RULE5]
		disable iff (SYS_RST_I)
		REG_WR_I && REG_PAGE_I == GCP_PAGE_CFG
		&& REG_ADDR_I == GCP_ADDR_IN_EN
		|=> in_en_reg == $past(REG_WDATA_I))
		else $error("input enable write lost");

	chk_pdm_only: assert property (@(posedge CLOCK_I) // [RULE6]
		disable iff (SYS_RST_I)
		PDM_ON_O[NUM_CH-GCP_NUM_ANALOG-1:0]
		== CH_STATUS_O[NUM_CH-GCP_NUM_ANALOG-1:0])
		else $error("channels 5-8 left the PDM path");

	chk_slot_drive: assert property (@(posedge CLOCK_I) // [RULE8]
		disable iff (SYS_RST_I)
		REG_WR_I && REG_PAGE_I == GCP_PAGE_CFG
		&& REG_ADDR_I == GCP_ADDR_SLOT_EN
		|=> SLOT_OE_O == $past(REG_WDATA_I)
		&& (SLOT_OUT_O & ~SLOT_OE_O) == '0)
		else $error("slot enable not applied");

	chk_bias_synth: assert property (@(posedge CLOCK_I) // [RULE10]
		disable iff (SYS_RST_I)
		REG_WR_I && REG_PAGE_I == GCP_PAGE_CFG
		&& REG_ADDR_I == GCP_ADDR_POWER_CONFIG
		|=> BIAS_ON_O == $past(REG_WDATA_I[GCP_PWR_BIAS])
		&& SYNTH_ON_O == $past(REG_WDATA_I[GCP_PWR_SYNTH])) // [RULE12]
		else $error("bias or synthesiser power wrong");

	chk_conv_off: assert property (@(posedge CLOCK_I) // [RULE11]
		disable iff (SYS_RST_I)
		!pwr_reg.conv_on |=> CH_STATUS_O == 8'h00)
		else $error("channel powered while converters off");

	chk_live_hold: assert property (@(posedge CLOCK_I) // [RULE14]
		disable iff (SYS_RST_I)
		recording && !pwr_reg.live && pwr_reg.conv_on
		|=> $stable(CH_STATUS_O))
		else $error("channel changed while recording");

	chk_span_hold: assert property (@(posedge CLOCK_I) // [RULE15]
		disable iff (SYS_RST_I)
		recording && pwr_reg.live && pwr_reg.conv_on
		|=> ((CH_STATUS_O ^ $past(CH_STATUS_O))
		& ~$past(span_mask)) == 8'h00)
		else $error("channel outside span changed");

	// read answer comes exactly one cycle after the strobe
	chk_read_pulse: assert property (@(posedge CLOCK_I) // [RULE5]
		disable iff (SYS_RST_I)
		REG_RVALID_O == $past(REG_RD_I))
		else $error("read answer not one cycle after strobe");

	chk_gain_readback: assert property (@(posedge CLOCK_I) // [RULE4]
		disable iff (SYS_RST_I)
		REG_RD_I && REG_PAGE_I == GCP_PAGE_CFG
		&& REG_ADDR_I == GCP_ADDR_GAIN_CFG
		|=> REG_RDATA_O == $past(gain_cfg_reg))
		else $error("gain config read back wrong");

	chk_pwr_readback: assert property (@(posedge CLOCK_I) // [RULE13]
		disable iff (SYS_RST_I)
		REG_RD_I && REG_PAGE_I == GCP_PAGE_CFG
		&& REG_ADDR_I == GCP_ADDR_POWER_CONFIG
		|=> REG_RDATA_O == $past(pwr_reg))
		else $error("power config read back wrong");

	// ceiling is base plus one 3 dB step per code, for every code
	chk_gain_step: assert property (@(posedge CLOCK_I) // [RULE2] [RULE16]
		disable iff (SYS_RST_I)
		!$past(SYS_RST_I) |-> AGC_GAIN_DB_O == GCP_GAIN_BASE_DB
		+ {3'h0, $past(gain_cfg_reg[GCP_GAIN_MSB:GCP_GAIN_LSB]), 1'b0}
		+ {4'h0, $past(gain_cfg_reg[GCP_GAIN_MSB:GCP_GAIN_LSB])})
		else $error("gain ceiling step wrong");

	// a powered channel 1-4 sits on exactly one path
	chk_analog_split: assert property (@(posedge CLOCK_I) // [RULE6]
		disable iff (SYS_RST_I)
		(ANALOG_ON_O & PDM_ON_O[NUM_CH-1 -: GCP_NUM_ANALOG]) == 4'h0
		&& (ANALOG_ON_O | PDM_ON_O[NUM_CH-1 -: GCP_NUM_ANALOG])
		== CH_STATUS_O[NUM_CH-1 -: GCP_NUM_ANALOG])
		else $error("channel 1-4 power split wrong");

	// a released slot never carries data
	chk_slot_mask: assert property (@(posedge CLOCK_I) // [RULE8]
		disable iff (SYS_RST_I)
		(SLOT_OUT_O & ~SLOT_OE_O) == '0)
		else $error("data shown on a released slot");

endmodule

// ===== verif/gcp_regs_tb.sv
// Purpose: self-checking bench for the gain, channel and power registers
// Assumes: inputs move 1 ns after the rising edge; read data one cycle on
// Notes:   each scenario is its own task; checks print and count mismatches

`timescale 1ns/1ps

module gcp_regs_tb
	import gcp_pkg::*;
;
	logic              clk;       // 20 MHz control clock
	logic              rst;       // sync reset, high
	logic [7:0]        page;      // register page
	logic [7:0]        addr;      // register address
	logic              wr;        // write strobe
	logic              rd;        // read strobe
	logic [7:0]        wdata;     // write data
	logic [7:0]        rdata;     // read data
	logic              rvalid;    // read data valid
	logic [3:0]        pdm_sel;   // ch1-4 source select
	logic [7:0]        slot_data; // per-slot serial bits
	logic [7:0]        slot_out;  // masked slot bits
	logic [7:0]        slot_oe;   // slot drive enables
	logic signed [7:0] level;     // decoded target level
	logic [7:0]        gain;      // decoded gain ceiling
	logic              gain_ok;   // gain code defined
	logic              bias;      // bias supply on
	logic              synth;     // synthesiser on
	logic [3:0]        analog;    // analog channel power
	logic [7:0]        pdm_on;    // pdm path power
	logic [7:0]        ch_stat;   // channel power state
	int                mismatches; // failed compares
	int                n_checks;   // all compares

	gcp_regs i_dut (
		.CLOCK_I(clk), .SYS_RST_I(rst), .REG_PAGE_I(page),
		.REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
		.CH_PDM_SEL_I(pdm_sel), .SLOT_DATA_I(slot_data),
		.SLOT_OUT_O(slot_out), .SLOT_OE_O(slot_oe),
		.AGC_LEVEL_DB_O(level), .AGC_GAIN_DB_O(gain),
		.AGC_GAIN_OK_O(gain_ok), .BIAS_ON_O(bias), .SYNTH_ON_O(synth),
		.ANALOG_ON_O(analog), .PDM_ON_O(pdm_on), .CH_STATUS_O(ch_stat)
	);

	// free-running clock, 50 ns period
	always #25 clk = ~clk;

	// one compare; four-state so an unknown never matches
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask

	// let n edges pass, then step off the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// one-cycle write strobe; strobe drops a full edge before any reuse
	task automatic wr_reg(input logic [7:0] pg, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk);
		#1;
		page = pg;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
	endtask

	// read with fixed one-cycle answer; valid must be a single pulse
	task automatic rd_chk(input logic [7:0] pg, input logic [7:0] a,
		input logic [7:0] exp, input string what);
		@(posedge clk);
		#1;
		page = pg;
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		chk("rvalid high", 8'h01, {7'h00, rvalid});
		chk(what, exp, rdata);
		cyc(1);
		chk("rvalid low", 8'h00, {7'h00, rvalid});
	endtask

	// reset values of all four registers and the outputs behind them
	task automatic t_reset();
		cyc(2);
		rd_chk(8'h00, GCP_ADDR_GAIN_CFG, 8'he7, "gain cfg");
		rd_chk(8'h00, GCP_ADDR_IN_EN, 8'hf0, "in enables");
		rd_chk(8'h00, GCP_ADDR_SLOT_EN, 8'h00, "slot en");
		rd_chk(8'h00, GCP_ADDR_POWER_CONFIG, 8'h00, "power_config");
		chk("level", 8'hde, level);
		chk("gain", 8'h18, gain);
		chk("gain ok", 8'h01, {7'h00, gain_ok});
		chk("slot oe", 8'h00, slot_oe);
		chk("slot out", 8'h00, slot_out);
		chk("pwr outs", 8'h00, {bias, synth, 6'h00});
		chk("ch status", 8'h00, ch_stat);
	endtask

	// every level code; gain codes stop short of the reserved pair,
	// which software is never allowed to program
	task automatic t_gain();
		int g; // gain code clamped to the last legal one
		for (int c = 0; c < 16; c++) begin
			g = (c > 13) ? 13 : c;
			wr_reg(8'h00, GCP_ADDR_GAIN_CFG, {c[3:0], g[3:0]});
			cyc(2);
			chk("level", 8'(-6 - 2 * c), level);
			chk("gain", 8'(3 + 3 * g), gain);
			chk("gain ok", 8'h01, {7'h00, gain_ok});
		end
		rd_chk(8'h00, GCP_ADDR_GAIN_CFG, 8'hfd, "gain cfg");
	endtask

	// enables steer channel power; ch3 taken from pdm to see both paths
	task automatic t_power();
		pdm_sel = 4'h2;
		wr_reg(8'h00, GCP_ADDR_IN_EN, 8'ha5);
		rd_chk(8'h00, GCP_ADDR_IN_EN, 8'ha5, "in enables");
		wr_reg(8'h00, GCP_ADDR_POWER_CONFIG, 8'h40);
		cyc(2);
		chk("ch status", 8'ha5, ch_stat);
		chk("analog on", 8'h08, {4'h0, analog});
		chk("pdm on", 8'h25, pdm_on);
		chk("bias synth", 8'h00, {bias, synth, 6'h00});
		wr_reg(8'h00, GCP_ADDR_POWER_CONFIG, 8'ha0);
		cyc(2);
		chk("ch status", 8'h00, ch_stat);
		chk("bias synth", 8'hc0, {bias, synth, 6'h00});
		wr_reg(8'h00, GCP_ADDR_POWER_CONFIG, 8'h00);
		cyc(2);
		chk("bias synth", 8'h00, {bias, synth, 6'h00});
	endtask

	// changes refused while recording, then each span code lets some in
	task automatic t_live();
		logic [7:0] exp_s [4];
		exp_s = '{8'h70, 8'h40, 8'h4c, 8'h4d};
		wr_reg(8'h00, GCP_ADDR_IN_EN, 8'hf0);
		wr_reg(8'h00, GCP_ADDR_POWER_CONFIG, 8'h40);
		wr_reg(8'h00, GCP_ADDR_IN_EN, 8'h4d);
		cyc(2);
		chk("frozen status", 8'hf0, ch_stat);
		for (int s = 0; s < 4; s++) begin
			wr_reg(8'h00, GCP_ADDR_POWER_CONFIG, 8'h50 | 8'(s << 2));
			cyc(2);
			chk("span status", exp_s[s], ch_stat);
		end
	endtask

	// slot drive enables and masked slot data
	task automatic t_slots();
		slot_data = 8'ha5;
		wr_reg(8'h00, GCP_ADDR_SLOT_EN, 8'h3c);
		cyc(2);
		chk("slot oe", 8'h3c, slot_oe);
		chk("slot out", 8'h24, slot_out);
		rd_chk(8'h00, GCP_ADDR_SLOT_EN, 8'h3c, "slot en");
	endtask

	// other pages and addresses take no write and read back zero
	task automatic t_unmapped();
		wr_reg(8'h01, GCP_ADDR_IN_EN, 8'h00);
		wr_reg(8'h00, 8'h71, 8'h00);
		rd_chk(8'h00, GCP_ADDR_IN_EN, 8'h4d, "in enables");
		rd_chk(8'h00, 8'h71, 8'h00, "unmapped read");
		rd_chk(8'h01, GCP_ADDR_POWER_CONFIG, 8'h00, "other page read");
	endtask

	// single exit point of the run
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// watchdog: a hung run counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out();
	end

	// main sequence, including a second reset after the last scenario
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{page, addr, wdata, wr, rd} = '0;
		pdm_sel = 4'h0;
		slot_data = 8'h00;
		mismatches = 0;
		n_checks = 0;
		cyc(3);
		rst = 1'b0;
		t_reset();
		t_gain();
		t_power();
		t_live();
		t_slots();
		t_unmapped();
		rst = 1'b1;
		cyc(3);
		rst = 1'b0;
		t_reset();
		close_out();
	end
endmodule
